// ==== common/cise_pkg.sv ====
// ==========================================================
// shared constants for the instruction subset executor
// ==========================================================
package cise_pkg;
    // register byte offsets
    localparam logic [11:0] OFF_CMD   = 12'h000;
    localparam logic [11:0] OFF_ACC   = 12'h004;
    localparam logic [11:0] OFF_STAT  = 12'h008;
    localparam logic [11:0] OFF_DIR1  = 12'h00C;
    localparam logic [11:0] OFF_DIR2  = 12'h010;
    localparam logic [11:0] OFF_DIR3  = 12'h014;
    localparam logic [11:0] OFF_WDOG  = 12'h018;
    localparam logic [2:0]  MEM_PAGE  = 3'h1;    // 0x200..0x3FC
    // command word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_DEST   = 4;
    localparam int CMD_F_LSB  = 8;
    localparam int CMD_K_LSB  = 16;
    // status bit positions
    localparam int ST_C     = 0;
    localparam int ST_DC    = 1;
    localparam int ST_Z     = 2;
    localparam int ST_PDN   = 3;
    localparam int ST_TON   = 4;
    localparam int ST_SLEEP = 5;
    // opcodes
    localparam logic [3:0] OP_SLEEP = 4'h1;
    localparam logic [3:0] OP_SUB   = 4'h2;
    localparam logic [3:0] OP_SUBB  = 4'h3;
    localparam logic [3:0] OP_SWAP  = 4'h4;
    localparam logic [3:0] OP_DIR   = 4'h5;
    localparam logic [3:0] OP_XORK  = 4'h6;
    localparam logic [3:0] OP_XORF  = 4'h7;
    // direction latch operand of the first port
    localparam logic [6:0] DIR_BASE = 7'h05;
    // reset values
    localparam logic [7:0] RST_ACC  = 8'h00;
    localparam logic [7:0] RST_DIR  = 8'hFF;
    localparam logic [7:0] RST_WDOG = 8'h00;
    // core state
    typedef enum logic [1:0] {
        CISE_RUN   = 2'b01,
        CISE_SLEEP = 2'b10
    } cise_state_t;
endpackage

// ==== logic/cise_core.sv ====
`timescale 1ns/1ps
// Overview of operation
// - sleep sets the expiry flag (active low) to one and clears the sleep-entered flag.
// - sleep clears the watchdog counter and its prescaler.
// - after sleep the core halts with its oscillator stopped until woken.
// - subtract computes register minus accumulator into accumulator or register per d.
// - borrow-not is 0 when accumulator exceeds operand, nibble flag likewise on bits 3:0.
// - subtract-with-borrow also takes away the inverted borrow-not flag, updating flags.
// - nibble exchange swaps the halves into the chosen destination, flags untouched.
// - direction load copies the accumulator to latch one, two, three for 5, 6, 7 only.
// - immediate exclusive-or puts accumulator xor literal in accumulator, zero flag only.
// - register exclusive-or puts accumulator xor register in the destination, zero only.
module cise_core #(
    parameter int MEM_DEPTH = 128,
    parameter int PRE_W     = 7,
    parameter int WDOG_W    = 8
) (
    // clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // wake pin, asynchronous
    input  wire logic        wake_pin,
    // core outputs
    output logic             osc_run,
    output logic [7:0]       port_one_direction,
    output logic [7:0]       port_two_direction,
    output logic [7:0]       port_three_direction
);

    // ==========================================================
    // elaboration checks
    // ==========================================================
    if (MEM_DEPTH < 8 || MEM_DEPTH > 128)
        $error("MEM_DEPTH must lie in 8..128");
    if (PRE_W < 1 || PRE_W > 16 || WDOG_W != 8)
        $error("bad watchdog widths");

    // ==========================================================
    // helpers
    // ==========================================================
    // zero test shared by every flag-updating result
    function automatic logic is_zero(input logic [7:0] v);
        return (v == 8'h00);
    endfunction

    // ==========================================================
    // state
    // ==========================================================
    cise_pkg::cise_state_t  state_reg;
    logic [7:0]             acc_reg;
    logic                   c_reg, dc_reg, z_reg;
    logic                   ton_reg, pdn_reg;
    logic [PRE_W-1:0]       pre_reg;
    logic [WDOG_W-1:0]      wdog_reg;
    logic [7:0]             mem [MEM_DEPTH];
    logic [7:0]             dir_reg [3];
    logic                   wake_s1_reg, wake_s2_reg;
    logic                   dp_valid_reg, dp_write_reg, rd_done_reg;
    logic [11:0]            dp_addr_reg;
    logic [31:0]            hrdata_reg;

    // ==========================================================
    // bus decode
    // ==========================================================
    // reads take one wait state so hrdata comes from a flop
    wire rd_pend   = dp_valid_reg & ~dp_write_reg & ~rd_done_reg;
    wire wr_now    = ce & dp_valid_reg & dp_write_reg;
    wire in_mem    = (dp_addr_reg[11:9] == cise_pkg::MEM_PAGE);
    wire [6:0] mix = dp_addr_reg[8:2];
    wire mem_ok    = in_mem & (int'(mix) < MEM_DEPTH);
    wire wr_cmd    = wr_now & (dp_addr_reg == cise_pkg::OFF_CMD);
    wire wr_acc    = wr_now & (dp_addr_reg == cise_pkg::OFF_ACC);
    wire wr_stat   = wr_now & (dp_addr_reg == cise_pkg::OFF_STAT);
    wire wr_mem    = wr_now & mem_ok;

    assign hreadyout = ce & ~rd_pend;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    // ==========================================================
    // command fields and datapath
    // ==========================================================
    wire [3:0] op   = hwdata[cise_pkg::CMD_OP_LSB +: 4];
    wire       dest = hwdata[cise_pkg::CMD_DEST];
    wire [6:0] fadr = hwdata[cise_pkg::CMD_F_LSB +: 7];
    wire [7:0] lit  = hwdata[cise_pkg::CMD_K_LSB +: 8];
    wire       fok  = (int'(fadr) < MEM_DEPTH);
    wire [7:0] fval = fok ? mem[fadr] : 8'h00;

    // commands are dropped while the core sleeps
    wire exec     = wr_cmd & (state_reg == cise_pkg::CISE_RUN);
    wire is_sleep = exec & (op == cise_pkg::OP_SLEEP);
    wire is_sub   = exec & (op == cise_pkg::OP_SUB);
    wire is_subb  = exec & (op == cise_pkg::OP_SUBB);
    wire is_swap  = exec & (op == cise_pkg::OP_SWAP);
    wire is_dir   = exec & (op == cise_pkg::OP_DIR);
    wire is_xork  = exec & (op == cise_pkg::OP_XORK);
    wire is_xorf  = exec & (op == cise_pkg::OP_XORF);

    // borrow in is the inverted borrow-not flag, only for subb
    wire       bin     = is_subb & ~c_reg;
    wire [8:0] sub9    = {1'b0, fval} - {1'b0, acc_reg}
                       - {8'h00, bin};
    wire [4:0] nib5    = {1'b0, fval[3:0]} - {1'b0, acc_reg[3:0]}
                       - {4'h0, bin};
    wire [7:0] swapped = {fval[3:0], fval[7:4]};
    wire [7:0] xk      = acc_reg ^ lit;
    wire [7:0] xf      = acc_reg ^ fval;

    wire [7:0] result = (is_sub | is_subb) ? sub9[7:0] :
                        is_swap            ? swapped   :
                        is_xork            ? xk        : xf;

    // destination select: d=0 accumulator, d=1 register
    wire f_dest  = is_sub | is_subb | is_swap | is_xorf;
    wire to_reg  = f_dest & dest & fok;
    wire to_acc  = (f_dest & ~dest) | is_xork;
    wire upd_c   = is_sub | is_subb;
    wire upd_z   = upd_c | is_xork | is_xorf;

    // direction latch index, only operands 5..7 act
    wire [6:0] dsel  = fadr - cise_pkg::DIR_BASE;
    wire       dir_v = is_dir & (fadr >= cise_pkg::DIR_BASE)
                     & (dsel < 7'd3);

    // ==========================================================
    // wake pin synchroniser
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wake_s1_reg <= 1'b0;
            wake_s2_reg <= 1'b0;
        end
        else if (ce)
        begin
            wake_s1_reg <= wake_pin;
            wake_s2_reg <= wake_s1_reg;
        end
    end

    // ==========================================================
    // bus phase tracking and read capture
    // ==========================================================
    wire [31:0] rd_val =
        (dp_addr_reg == cise_pkg::OFF_ACC)  ? {24'h0000_00, acc_reg} :
        (dp_addr_reg == cise_pkg::OFF_STAT) ? {26'h000_0000, state_reg
                                               == cise_pkg::CISE_SLEEP,
                                               ton_reg, pdn_reg, z_reg,
                                               dc_reg, c_reg} :
        (dp_addr_reg == cise_pkg::OFF_DIR1) ? {24'h0000_00, dir_reg[0]} :
        (dp_addr_reg == cise_pkg::OFF_DIR2) ? {24'h0000_00, dir_reg[1]} :
        (dp_addr_reg == cise_pkg::OFF_DIR3) ? {24'h0000_00, dir_reg[2]} :
        (dp_addr_reg == cise_pkg::OFF_WDOG) ? {16'h0000, wdog_reg,
                                               (8)'(pre_reg)} :
        mem_ok                              ? {24'h0000_00, mem[mix]} :
                                              32'h0000_0000;

    // address phase is taken only while hready is high
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg  <= 12'h000;
            rd_done_reg  <= 1'b0;
            hrdata_reg   <= 32'h0000_0000;
        end
        else if (ce)
        begin
            if (rd_pend)
            begin
                hrdata_reg  <= rd_val;
                rd_done_reg <= 1'b1;
            end
            else if (hready)
            begin
                dp_valid_reg <= hsel & htrans[1];
                dp_write_reg <= hwrite;
                dp_addr_reg  <= haddr[11:0];
                rd_done_reg  <= 1'b0;
            end
        end
    end

    // ==========================================================
    // core state: run or sleep
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state_reg <= cise_pkg::CISE_RUN;
        else if (ce)
        begin
            case (state_reg)
                cise_pkg::CISE_RUN:
                    if (is_sleep)
                        state_reg <= cise_pkg::CISE_SLEEP;
                cise_pkg::CISE_SLEEP:
                    if (wake_s2_reg)
                        state_reg <= cise_pkg::CISE_RUN;
                default:
                    state_reg <= cise_pkg::CISE_RUN;
            endcase
        end
    end

    // oscillator stops for the whole sleep
    assign osc_run = (state_reg == cise_pkg::CISE_RUN);

    // ==========================================================
    // watchdog counter and prescaler
    // ==========================================================
    // counts only on running core cycles; sleep clears both
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pre_reg  <= '0;
            wdog_reg <= cise_pkg::RST_WDOG;
        end
        else if (ce)
        begin
            if (is_sleep)
            begin
                pre_reg  <= '0;
                wdog_reg <= cise_pkg::RST_WDOG;
            end
            else if (osc_run)
            begin
                pre_reg <= pre_reg + 1'b1;
                if (&pre_reg)
                    wdog_reg <= wdog_reg + 1'b1;
            end
        end
    end

    // ==========================================================
    // accumulator and status flags
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acc_reg <= cise_pkg::RST_ACC;
            c_reg   <= 1'b0;
            dc_reg  <= 1'b0;
            z_reg   <= 1'b0;
            ton_reg <= 1'b1;
            pdn_reg <= 1'b1;
        end
        else if (ce)
        begin
            if (wr_acc)
                acc_reg <= hwdata[7:0];
            else if (to_acc)
                acc_reg <= result;
            if (wr_stat)
            begin
                c_reg  <= hwdata[cise_pkg::ST_C];
                dc_reg <= hwdata[cise_pkg::ST_DC];
                z_reg  <= hwdata[cise_pkg::ST_Z];
            end
            if (upd_c)
            begin
                c_reg  <= ~sub9[8];
                dc_reg <= ~nib5[4];
            end
            if (upd_z)
                z_reg <= is_zero(result);
            if (is_sleep)
            begin
                ton_reg <= 1'b1;
                pdn_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // data memory, no reset: contents are undefined at power up
    // ==========================================================
    always_ff @(posedge hclk)
    begin
        if (ce && wr_mem)
            mem[mix] <= hwdata[7:0];
        else if (ce && to_reg)
            mem[fadr] <= result;
    end

    // ==========================================================
    // port direction latches
    // ==========================================================
    for (genvar g = 0; g < 3; g++)
    begin : g_dir
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
                dir_reg[g] <= cise_pkg::RST_DIR;
            else if (ce && dir_v && dsel == 7'(g))
                dir_reg[g] <= acc_reg;
        end
    end

    assign port_one_direction   = dir_reg[0];
    assign port_two_direction   = dir_reg[1];
    assign port_three_direction = dir_reg[2];

    // ==========================================================
    // checks
    // ==========================================================
    a_sleep_flags: assert property (@(posedge hclk) disable iff (!hresetn)
        is_sleep |=> ton_reg && !pdn_reg)
        else $error("sleep did not update power flags");
    a_wdog_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        is_sleep |=> wdog_reg == '0 && pre_reg == '0)
        else $error("sleep did not clear watchdog");
    a_sleep_halt: assert property (@(posedge hclk) disable iff (!hresetn)
        is_sleep ##1 (!wake_s2_reg)[*2] |=> !osc_run && !exec)
        else $error("core left sleep without wake");
    a_sub_result: assert property (@(posedge hclk) disable iff (!hresetn)
        is_sub && !dest |=> acc_reg == $past(fval) - $past(acc_reg))
        else $error("subtract result wrong");
    a_borrow_flags: assert property (@(posedge hclk) disable iff (!hresetn)
        is_sub |=> c_reg == ($past(acc_reg) <= $past(fval))
                   && dc_reg == ($past(acc_reg[3:0]) <= $past(fval[3:0])))
        else $error("borrow flags wrong");
    a_subb_result: assert property (@(posedge hclk) disable iff (!hresetn)
        is_subb && !dest && !c_reg |=> acc_reg == $past(fval)
                   - $past(acc_reg) - 8'h01)
        else $error("borrow subtract wrong");
    a_swap_flags: assert property (@(posedge hclk) disable iff (!hresetn)
        is_swap && !dest |=> $stable(c_reg) && $stable(dc_reg)
                   && $stable(z_reg) && acc_reg[7:4] == $past(fval[3:0]))
        else $error("swap wrong or touched flags");
    a_dir_load: assert property (@(posedge hclk) disable iff (!hresetn)
        is_dir && fadr == 7'h06 |=> port_two_direction == $past(acc_reg)
                   && $stable(port_one_direction) && $stable(z_reg))
        else $error("direction latch load wrong");
    a_xork_acc: assert property (@(posedge hclk) disable iff (!hresetn)
        is_xork |=> acc_reg == ($past(acc_reg) ^ $past(lit)) && $stable(c_reg))
        else $error("literal xor wrong");

    a_xorf_reg: assert property (@(posedge hclk) disable iff (!hresetn)
        is_xorf && dest && fok |=> $stable(acc_reg) && $stable(dc_reg))
        else $error("register xor touched accumulator");

    a_zero_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        upd_z |=> z_reg == ($past(result) == 8'h00))
        else $error("zero flag wrong");

endmodule // cise_core

// ==== sim/cpu_instruction_subset_exec_tb.sv ====
`timescale 1ns/1ps
module cpu_instruction_subset_exec_tb;
    // ==========================================================
    // signals
    // ==========================================================
    logic        hclk;
    logic        hresetn;
    logic        ce;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        wake_pin;
    logic        osc_run;
    logic [7:0]  dir_one;
    logic [7:0]  dir_two;
    logic [7:0]  dir_three;
    logic [31:0] rd;
    logic [7:0]  exp_dir [3];
    int          error_cnt;
    int          total_checks;
    // file register 9 sits at 0x200 + 4*9
    localparam logic [11:0] MEM_F = 12'h224;

    // clock at 20 MHz
    always #25 hclk = ~hclk;

    // single slave, so its ready is the bus ready
    cise_core #(.MEM_DEPTH(128), .PRE_W(7), .WDOG_W(8)) uut (
        .hclk                 (hclk),
        .hresetn              (hresetn),
        .ce                   (ce),
        .hsel                 (hsel),
        .haddr                (haddr),
        .htrans               (htrans),
        .hwrite               (hwrite),
        .hsize                (hsize),
        .hwdata               (hwdata),
        .hready               (hreadyout),
        .hreadyout            (hreadyout),
        .hresp                (hresp),
        .hrdata               (hrdata),
        .wake_pin             (wake_pin),
        .osc_run              (osc_run),
        .port_one_direction   (dir_one),
        .port_two_direction   (dir_two),
        .port_three_direction (dir_three)
    );

    // ==========================================================
    // reporting
    // ==========================================================
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================================
    // bus master tasks, entered just after a rising edge
    // ==========================================================
    // bounded wait, so a stuck slave ends the run instead of hanging it
    task automatic wait_ready;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (hreadyout !== 1'b1)
        begin
            check("hreadyout", {31'h0, hreadyout}, 32'h0000_0001);
            summarize();
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {20'h0000, a};
        hwrite <= wr;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        if (wr)
            hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(name, rd, exp);
    endtask

    task automatic exec(input logic [3:0] op, input logic d, input logic [6:0] f,
                        input logic [7:0] k);
        wr(cise_pkg::OFF_CMD, {8'h00, k, 1'b0, f, 3'b000, d, op});
    endtask

    // loads operands and flags, runs one instruction, compares result and flags
    task automatic run_op(input logic [3:0] op, input logic d, input logic [7:0] fv,
                          input logic [7:0] w, input logic [2:0] st);
        logic [8:0] df;
        logic [4:0] dn;
        logic [7:0] res;
        logic [2:0] fl;
        logic       bin;
        wr(MEM_F, {24'h0000_00, fv});
        wr(cise_pkg::OFF_ACC, {24'h0000_00, w});
        wr(cise_pkg::OFF_STAT, {29'h0000_0000, st});
        exec(op, d, 7'h09, fv);
        bin = (op == cise_pkg::OP_SUBB) ? ~st[0] : 1'b0;
        df  = {1'b0, fv} - {1'b0, w} - {8'h00, bin};
        dn  = {1'b0, fv[3:0]} - {1'b0, w[3:0]} - {4'h0, bin};
        fl  = st;
        res = w ^ fv;
        if (op == cise_pkg::OP_SUB || op == cise_pkg::OP_SUBB)
        begin
            res = df[7:0];
            fl  = {res == 8'h00, ~dn[4], ~df[8]};
        end
        else if (op == cise_pkg::OP_SWAP)
            res = {fv[3:0], fv[7:4]};
        else
            fl[2] = (res == 8'h00);
        // literal form always lands in the accumulator and never touches memory
        if (d && op != cise_pkg::OP_XORK)
        begin
            rd_chk("file register", MEM_F, {24'h0000_00, res});
            rd_chk("accumulator", cise_pkg::OFF_ACC, {24'h0000_00, w});
        end
        else
        begin
            rd_chk("accumulator", cise_pkg::OFF_ACC, {24'h0000_00, res});
            rd_chk("file register", MEM_F, {24'h0000_00, fv});
        end
        rd_chk("status", cise_pkg::OFF_STAT, {26'h0, 3'b011, fl});
    endtask

    // ==========================================================
    // main sequence
    // ==========================================================
    initial
    begin
        hclk = 1'b0; hresetn = 1'b0; ce = 1'b1; hsel = 1'b0; haddr = 32'h0000_0000;
        htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0000_0000;
        wake_pin = 1'b0; error_cnt = 0; total_checks = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("status after reset", cise_pkg::OFF_STAT, 32'h0000_0018);
        rd_chk("unmapped", 12'h100, 32'h0000_0000);
        check("hresp", {31'h0, hresp}, 32'h0000_0000);
        // subtract family borrow boundaries, then swap and both xor forms, each run with d=0 and with d=1
        run_op(cise_pkg::OP_SUB,  1'b0, 8'h10, 8'h11, 3'h0);
        run_op(cise_pkg::OP_SUB,  1'b1, 8'h25, 8'h25, 3'h7);
        run_op(cise_pkg::OP_SUB,  1'b0, 8'h40, 8'h0F, 3'h0);
        run_op(cise_pkg::OP_SUBB, 1'b0, 8'h25, 8'h25, 3'h0);
        run_op(cise_pkg::OP_SUBB, 1'b1, 8'h25, 8'h24, 3'h0);
        run_op(cise_pkg::OP_SUBB, 1'b0, 8'h80, 8'h01, 3'h1);
        run_op(cise_pkg::OP_SWAP, 1'b0, 8'hA5, 8'h00, 3'h5);
        run_op(cise_pkg::OP_SWAP, 1'b1, 8'h3C, 8'hFF, 3'h2);
        run_op(cise_pkg::OP_XORF, 1'b1, 8'hF0, 8'hF0, 3'h3);
        run_op(cise_pkg::OP_XORF, 1'b0, 8'h0F, 8'hF0, 3'h4);
        run_op(cise_pkg::OP_XORK, 1'b1, 8'hAA, 8'hAA, 3'h0);
        run_op(cise_pkg::OP_XORK, 1'b0, 8'h01, 8'h80, 3'h7);
        // direction loads: operands 4 and 8 lie outside the legal range
        exp_dir = '{8'hFF, 8'hFF, 8'hFF};
        wr(cise_pkg::OFF_STAT, 32'h0000_0005);
        for (int i = 4; i <= 8; i++)
        begin
            wr(cise_pkg::OFF_ACC, 32'h0000_0010 + i);
            exec(cise_pkg::OP_DIR, 1'b0, i[6:0], 8'h00);
            @(posedge hclk); // latch updates on the edge that ends the data phase
            if (i >= 5 && i <= 7)
                exp_dir[i-5] = 8'h10 + i[7:0];
            check("direction one", {24'h0, dir_one}, {24'h0, exp_dir[0]});
            check("direction two", {24'h0, dir_two}, {24'h0, exp_dir[1]});
            check("direction three", {24'h0, dir_three}, {24'h0, exp_dir[2]});
        end
        wr(cise_pkg::OFF_DIR1, 32'h0000_0000);
        rd_chk("direction one reg", cise_pkg::OFF_DIR1, 32'h0000_0015);
        rd_chk("direction three reg", cise_pkg::OFF_DIR3, 32'h0000_0017);
        rd_chk("status after loads", cise_pkg::OFF_STAT, 32'h0000_001D);
        // sleep: flags, watchdog clear, halt, ignored command, wake
        wr(cise_pkg::OFF_ACC, 32'h0000_0066);
        repeat (150) @(posedge hclk);
        exec(cise_pkg::OP_SLEEP, 1'b0, 7'h00, 8'h00);
        rd_chk("status in sleep", cise_pkg::OFF_STAT, 32'h0000_0035);
        rd_chk("watchdog in sleep", cise_pkg::OFF_WDOG, 32'h0000_0000);
        check("oscillator in sleep", {31'h0, osc_run}, 32'h0000_0000);
        exec(cise_pkg::OP_XORK, 1'b0, 7'h00, 8'h66);
        rd_chk("accumulator in sleep", cise_pkg::OFF_ACC, 32'h0000_0066);
        rd_chk("watchdog still clear", cise_pkg::OFF_WDOG, 32'h0000_0000);
        wake_pin <= 1'b1;
        for (int n = 0; n < 20 && osc_run !== 1'b1; n++)
            @(posedge hclk);
        wake_pin <= 1'b0;
        check("oscillator after wake", {31'h0, osc_run}, 32'h0000_0001);
        @(posedge hclk);
        rd_chk("status after wake", cise_pkg::OFF_STAT, 32'h0000_0015);
        summarize();
    end
endmodule // cpu_instruction_subset_exec_tb
